// ===== sfe_exception_unit.sv
// SIMD floating-point exception detection, flagging and fault sequencing with APB access.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Divide of finite non-zero by zero flags.
// - Divide-by-zero flag bit 2, mask bit 9.
// - Divide-by-zero ignores flush-to-zero.
// - Rounded result beyond largest finite means overflow.
// - Overflow flag bit 3, mask bit 10.
// - Overflow ignores flush-to-zero and denormals-as-zero.
// - Underflow: tiny; when masked, tiny and inexact.
// - Underflow flag bit 4, mask bit 11.
// - Flush-to-zero with masked underflow writes signed zero.
// - Unrepresentable result raises inexact.
// - Flushed results still report inexact.
// - Pre-computation checks first, post-computation second.
// - Both phases unmasked may fault twice.
// - All masked: write results, no fault.
// - Masked flags set; lone tiny leaves underflow clear.
// - Per-lane flags ORed into register flags.
// - Unmasked pre conditions flagged, operands untouched, signalled.
// - OS enable picks simd or invalid-opcode fault.
// - Post conditions after return, signalled same way.
// - Complete only after post handler returns.
// - Mixed: set all flags, hold results until return.
// - Denormal flag bit 1, mask bit 8.
// - Reset sets masks, clears flags.
module sfe_exception_unit
  import sfe_pkg::*;
#(
  parameter int LANES = 4
)(
  // Clock and reset.
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [CSR_W-1:0]      pwdata,
  output var  logic [CSR_W-1:0]      prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Instruction from the pipeline.
  input  wire logic                  instr_valid,
  output logic                       instr_ready,
  input  wire sfe_lane_t [LANES-1:0] lanes,
  // Control register four enable bit.
  input  wire logic                  os_simd_fault_enable,
  // Fault dispatch.
  output sfe_fault_t                 fault,
  input  wire logic                  fault_return,
  // Result commit.
  output logic                       commit_valid,
  output var  logic [LANES-1:0]      flush_lanes,
  output var  logic [LANES-1:0]      flush_sign
);

  if (LANES < 1 || LANES > 16)
  begin : g_check
    $error("LANES must lie between 1 and 16.");
  end

  sfe_state_t                  state_q, state_d;
  sfe_lane_t [LANES-1:0]       lanes_q;
  logic      [CSR_W-1:0]       csr_q, csr_d;
  sfe_fault_t                  fault_q, fault_d;
  sfe_fault_kind_t             last_kind_q;
  logic      [NFLAGS-1:0]      last_flags_q;
  logic      [CSR_W-1:0]       prdata_q;
  logic      [LANES-1:0]       flush_q, fsign_q;

  function automatic logic [NFLAGS-1:0] unmasked(input logic [NFLAGS-1:0] f,
                                                  input logic [CSR_W-1:0]  c);
    unmasked = f & ~c[MASK_LO +: NFLAGS];
  endfunction

  // The OS enable decides which fault the dispatch sees, in either phase.
  function automatic sfe_fault_kind_t kind_of(input logic os_en);
    kind_of = os_en ? FAULT_SIMD_FP : FAULT_INVALID_OPCODE;
  endfunction

  // Control fields.
  wire logic ftz      = csr_q[FTZ_BIT];
  wire logic denorm_zero = csr_q[DENORM_ZERO_BIT];
  wire logic unf_mask = csr_q[MASK_LO + FLAG_UNF];

  // Per-lane detection and OR across lanes.
  logic [NFLAGS-1:0] lane_flags [LANES];
  logic [NFLAGS-1:0] or_chain   [LANES+1];
  logic [LANES-1:0]  lane_flush;
  logic [LANES-1:0]  lane_ti;
  assign or_chain[0] = '0;

  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    wire sfe_lane_t ln = lanes_q[l];
    // Denormal sources become zeros when denormals-as-zero is on.
    assign lane_flags[l][FLAG_INV] = ln.invalid;
    assign lane_flags[l][FLAG_DEN] = ln.denormal_src & ~denorm_zero;
    assign lane_flags[l][FLAG_DZ]  = ln.is_div & ln.dividend_ok & ln.divisor_zero;
    assign lane_flags[l][FLAG_OVF] = ln.overflow;
    assign lane_flags[l][FLAG_UNF] = ln.tiny & (ln.inexact | ~unf_mask);
    assign lane_flags[l][FLAG_INX] = ln.inexact | lane_flush[l];
    assign lane_flush[l]           = ln.tiny & ftz & unf_mask;
    assign or_chain[l+1]           = or_chain[l] | lane_flags[l];
    // Raw tiny and inexact pair, kept for the underflow check below.
    assign lane_ti[l]              = ln.tiny & ln.inexact;
  end

  wire logic [NFLAGS-1:0] or_flags = or_chain[LANES];
  wire logic [NFLAGS-1:0] pre_set  = or_flags & PRE_SEL;
  wire logic [NFLAGS-1:0] post_set = or_flags & POST_SEL;
  wire logic              pre_trap  = |unmasked(pre_set, csr_q);
  wire logic              post_trap = |unmasked(post_set, csr_q);

  // Both masked and unmasked flags of a phase are recorded.
  wire logic [NFLAGS-1:0] flag_set =
      (state_q == ST_PRE)  ? pre_set  :
      (state_q == ST_POST) ? post_set : '0;

  // APB decode.
  wire logic setup    = psel & ~penable;
  wire logic access   = psel & penable;
  wire logic hit_csr  = (paddr == OFF_CSR);
  wire logic hit_stat = (paddr == OFF_STAT);
  wire logic bad      = ~hit_csr & ~(hit_stat & ~pwrite);
  wire logic csr_wr   = access & pwrite & hit_csr;

  wire logic [CSR_W-1:0] stat_word =
      (CSR_W'(state_q) << STAT_STATE_LO) |
      (CSR_W'(last_kind_q) << STAT_KIND) |
      (CSR_W'(last_flags_q) << STAT_FLAGS_LO);
  wire logic [CSR_W-1:0] rd_mux = hit_csr ? csr_q : (hit_stat ? stat_word : '0);

  // A flag raised in the cycle of a software write survives that write.
  wire logic [CSR_W-1:0] csr_base = csr_wr ? (pwdata & CSR_WMASK) : csr_q;
  assign csr_d = csr_base | (CSR_W'(flag_set) << FLAG_INV);

  assign pready  = 1'b1;
  assign pslverr = access & bad;
  assign prdata  = prdata_q;

  // Sequencer.
  always_comb
  begin
    state_d = state_q;
    fault_d = '0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (instr_valid)
        begin
          state_d = ST_PRE;
        end
      end
      ST_PRE:
      begin
        if (pre_trap)
        begin
          fault_d.valid = 1'b1;
          fault_d.post  = 1'b0;
          fault_d.kind  = kind_of(os_simd_fault_enable);
          state_d = ST_PRE_WAIT;
        end
        else
        begin
          state_d = ST_POST;
        end
      end
      ST_PRE_WAIT:
      begin
        if (fault_return)
        begin
          state_d = ST_POST;
        end
      end
      ST_POST:
      begin
        if (post_trap)
        begin
          fault_d.valid = 1'b1;
          fault_d.post  = 1'b1;
          fault_d.kind  = kind_of(os_simd_fault_enable);
          state_d = ST_POST_WAIT;
        end
        else
        begin
          state_d = ST_DONE;
        end
      end
      ST_POST_WAIT:
      begin
        if (fault_return)
        begin
          state_d = ST_DONE;
        end
      end
      ST_DONE:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign instr_ready  = (state_q == ST_IDLE);
  assign commit_valid = (state_q == ST_DONE);
  assign fault        = fault_q;
  assign flush_lanes  = flush_q;
  assign flush_sign   = fsign_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      csr_q   <= CSR_RESET;
      fault_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      csr_q   <= csr_d;
      fault_q <= fault_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lanes_q      <= '0;
      last_kind_q  <= FAULT_SIMD_FP;
      last_flags_q <= '0;
      prdata_q     <= '0;
      flush_q      <= '0;
      fsign_q      <= '0;
    end
    else
    begin
      if (instr_valid && instr_ready)
      begin
        lanes_q <= lanes;
      end
      if (fault_d.valid)
      begin
        last_kind_q <= fault_d.kind;
      end
      if (state_q == ST_POST)
      begin
        last_flags_q <= or_flags;
        flush_q      <= lane_flush;
        for (int l = 0; l < LANES; l++)
        begin
          fsign_q[l] <= lanes_q[l].sign;
        end
      end
      if (setup)
      begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Checks.
  fault_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_q.valid |=> !fault_q.valid) else $error("Fault request longer than one cycle.");

  fault_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_q.valid |-> (fault_q.kind == ($past(os_simd_fault_enable) ? FAULT_SIMD_FP
                                         : FAULT_INVALID_OPCODE)))
    else $error("Fault kind does not follow the OS enable.");

  divzero_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_PRE && or_flags[FLAG_DZ]) |=> csr_q[FLAG_DZ])
    else $error("Divide-by-zero flag not set.");

  overflow_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_POST && or_flags[FLAG_OVF]) |=> csr_q[FLAG_OVF])
    else $error("Overflow flag not set.");

  lone_tiny_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_POST && unf_mask && !(|lane_ti) && !csr_q[FLAG_UNF] && !csr_wr)
    |=> !csr_q[FLAG_UNF]) else $error("Underflow flag set without inexact.");

  sticky_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!csr_wr && csr_q[FLAG_INX]) |=> csr_q[FLAG_INX])
    else $error("Inexact flag dropped without a write.");

  hold_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    commit_valid |-> (($past(state_q) == ST_POST && !$past(post_trap))
                      || ($past(state_q) == ST_POST_WAIT && $past(fault_return))))
    else $error("Results committed before the post handler returned.");

  pre_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_q.valid && !fault_q.post) |-> (state_q == ST_PRE_WAIT && $past(state_q) == ST_PRE))
    else $error("Pre-computation fault outside the first phase.");

  masked_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_POST && !post_trap) |=> commit_valid)
    else $error("Masked instruction did not complete.");

  masked_pre_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_PRE && !pre_trap) |=> !fault_q.valid)
    else $error("Fault raised for masked pre-computation conditions.");

  pre_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_PRE && pre_trap) |=> (fault_q.valid && !fault_q.post))
    else $error("Unmasked pre-computation condition not signalled.");

  divzero_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_PRE && or_flags[FLAG_DZ] && !csr_q[MASK_LO + FLAG_DZ]) |=> fault_q.valid)
    else $error("Unmasked divide-by-zero did not fault.");

  overflow_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_POST && or_flags[FLAG_OVF] && !csr_q[MASK_LO + FLAG_OVF]) |=> fault_q.valid)
    else $error("Unmasked overflow did not fault.");

  denormal_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_PRE && or_flags[FLAG_DEN]) |=> csr_q[FLAG_DEN])
    else $error("Denormal flag not set.");

  underflow_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_POST && or_flags[FLAG_UNF]) |=> csr_q[FLAG_UNF])
    else $error("Underflow flag not set.");

  inexact_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_POST && or_flags[FLAG_INX]) |=> csr_q[FLAG_INX])
    else $error("Inexact flag not set.");

  flush_inexact_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_POST && |lane_flush) |=> csr_q[FLAG_INX])
    else $error("Flushed result did not report inexact.");

  post_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_POST) |-> ($past(state_q) inside {ST_PRE, ST_PRE_WAIT}))
    else $error("Post-computation phase entered out of order.");

  post_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_q.valid && fault_q.post) |-> ($past(state_q) == ST_POST))
    else $error("Post-computation fault outside the second phase.");

  commit_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    commit_valid |=> !commit_valid)
    else $error("Commit request longer than one cycle.");

  operands_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !instr_ready |=> $stable(lanes_q))
    else $error("Operands changed while an instruction was in flight.");

endmodule

`default_nettype wire

// ===== sfe_pkg.sv
// Constants, field positions and carrier types for the SIMD floating-point exception unit.
package sfe_pkg;

  // Control/status register field positions.
  localparam int FLAG_INV  = 0;
  localparam int FLAG_DEN  = 1;
  localparam int FLAG_DZ   = 2;
  localparam int FLAG_OVF  = 3;
  localparam int FLAG_UNF  = 4;
  localparam int FLAG_INX  = 5;
  localparam int DENORM_ZERO_BIT = 6;
  localparam int MASK_LO   = 7;
  localparam int FTZ_BIT   = 15;
  localparam int NFLAGS    = 6;
  localparam int CSR_W     = 32;

  localparam logic [CSR_W-1:0] CSR_RESET = 32'h0000_1f80;
  localparam logic [CSR_W-1:0] CSR_WMASK = 32'h0000_ffff;

  // Flag groups, indexed like the flag field of the register.
  localparam logic [NFLAGS-1:0] PRE_SEL  = 6'h07;
  localparam logic [NFLAGS-1:0] POST_SEL = 6'h38;

  // APB map.
  localparam int              ADDR_W   = 12;
  localparam logic [ADDR_W-1:0] OFF_CSR  = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STAT = 12'h004;

  // Status register layout.
  localparam int STAT_STATE_LO = 0;
  localparam int STAT_KIND     = 4;
  localparam int STAT_FLAGS_LO = 8;

  typedef enum logic [0:0] {
    FAULT_SIMD_FP        = 1'b0,
    FAULT_INVALID_OPCODE = 1'b1
  } sfe_fault_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_PRE       = 3'b001,
    ST_PRE_WAIT  = 3'b010,
    ST_POST      = 3'b011,
    ST_POST_WAIT = 3'b100,
    ST_DONE      = 3'b101
  } sfe_state_t;

  // Raw conditions of one lane as found by the datapath.
  typedef struct packed {
    logic is_div;
    logic dividend_ok;
    logic divisor_zero;
    logic invalid;
    logic denormal_src;
    logic overflow;
    logic tiny;
    logic inexact;
    logic sign;
  } sfe_lane_t;

  typedef struct packed {
    logic            valid;
    sfe_fault_kind_t kind;
    logic            post;
  } sfe_fault_t;

endpackage

// ===== sfe_pipe_model.sv
// Behavioural pipeline model that returns from each fault handler after a set delay.
`timescale 1ns/100ps
`default_nettype none
module sfe_pipe_model
  import sfe_pkg::*;
(
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Fault dispatch.
  input  wire sfe_fault_t fault,
  input  wire logic [7:0] ret_dly,
  output var  logic       fault_return
);
  logic [7:0] cnt_q;

  // The handler returns ret_dly cycles after the pulse; ret_dly must be at least one.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q        <= 8'h00;
      fault_return <= 1'b0;
    end
    else
    begin
      fault_return <= (cnt_q == 8'h01);
      if (fault.valid)
        cnt_q <= ret_dly;
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the SIMD floating-point exception unit.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sfe_pkg::*;
  localparam logic [8:0] L0 = 9'h000, L_DZ = 9'h1c0, L_DEN = 9'h010, L_OVF = 9'h008;
  localparam logic [8:0] L_TI = 9'h006, L_T = 9'h004, L_Z0 = 9'h140, L_TS = 9'h005;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [ADDR_W-1:0]     paddr = '0;
  logic [CSR_W-1:0]      pwdata = '0;
  logic [CSR_W-1:0]      prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  instr_valid = 1'b0;
  logic                  instr_ready;
  sfe_lane_t [3:0]       lanes = '0;
  logic                  os_en = 1'b1;
  sfe_fault_t            fault;
  logic                  fault_return;
  logic                  commit_valid;
  logic [3:0]            flush_lanes;
  logic [3:0]            flush_sign;
  logic [7:0]            ret_dly = 8'h01;
  logic [31:0]           rd;
  logic                  er;
  logic [1:0]            fk [0:1];
  int                    nf;
  int                    n_errors = 0;
  int                    checked = 0;
  int                    cycles = 0;

  always #5 pclk = ~pclk;

  sfe_exception_unit #(.LANES(4)) sfe_exception_unit_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .lanes(lanes), .os_simd_fault_enable(os_en), .fault(fault),
    .fault_return(fault_return), .commit_valid(commit_valid), .flush_lanes(flush_lanes),
    .flush_sign(flush_sign));

  sfe_pipe_model sfe_pipe_model_i (.pclk(pclk), .presetn(presetn), .fault(fault),
    .ret_dly(ret_dly), .fault_return(fault_return));

  task end_of_test();
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task csr(input logic [31:0] exp);
    apb(1'b0, OFF_CSR, 32'h0);
    chk(rd, exp);
  endtask

  // Offers one instruction and follows it through both phases up to the commit pulse.
  task run(input logic [35:0] l, input logic en, input logic [7:0] d);
    logic done;
    @(posedge pclk);
    lanes       <= l;
    os_en       <= en;
    ret_dly     <= d;
    instr_valid <= 1'b1;
    @(posedge pclk);
    while (instr_ready !== 1'b1)
      @(posedge pclk);
    instr_valid <= 1'b0;
    nf = 0;
    done = 1'b0;
    repeat (60)
      if (!done)
      begin
        @(negedge pclk);
        if (fault.valid === 1'b1)
        begin
          if (nf < 2)
            fk[nf] = {fault.kind, fault.post};
          nf++;
        end
        if (commit_valid === 1'b1)
          done = 1'b1;
      end
    chk({31'h0, done}, 32'h1);
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    csr(32'h0000_1f80);
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, OFF_STAT, 32'h0);
    chk({31'h0, er}, 32'h1);
    run({L_TI, L_OVF, L_DEN, L_DZ}, 1'b1, 8'h01);
    chk(32'(nf), 32'h0);
    csr(32'h0000_1fbe);
    apb(1'b1, OFF_CSR, 32'hffff_1f80);
    csr(32'h0000_1f80);
    run({L0, L0, L_T, L_Z0}, 1'b1, 8'h01);
    csr(32'h0000_1f80);
    apb(1'b1, OFF_CSR, 32'h0000_9f80);
    run({L0, L_TS, L0, L_DZ}, 1'b1, 8'h01);
    chk({28'h0, flush_lanes}, 32'h4);
    chk({28'h0, flush_sign}, 32'h4);
    apb(1'b0, OFF_CSR, 32'h0);
    chk(rd & 32'h24, 32'h24);
    apb(1'b1, OFF_CSR, 32'h0);
    run({L0, L0, L_OVF, L_DZ}, 1'b1, 8'h05);
    chk(32'(nf), 32'h2);
    chk({30'h0, fk[0]}, 32'h0);
    chk({30'h0, fk[1]}, 32'h1);
    csr(32'h0000_000c);
    apb(1'b1, OFF_CSR, 32'h0);
    run({L0, L0, L0, L_DEN}, 1'b0, 8'h02);
    chk(32'(nf), 32'h1);
    chk({30'h0, fk[0]}, 32'h2);
    csr(32'h0000_0002);
    apb(1'b1, OFF_CSR, 32'h0000_1b80);
    run({L0, L0, L_TI, L_OVF}, 1'b1, 8'h03);
    chk(32'(nf), 32'h1);
    chk({30'h0, fk[0]}, 32'h1);
    csr(32'h0000_1bb8);
    run({L0, L0, L0, L0}, 1'b1, 8'h01);
    chk(32'(nf), 32'h0);
    csr(32'h0000_1bb8);
    apb(1'b1, OFF_CSR, 32'h0000_1780);
    run({L0, L0, L0, L_T}, 1'b1, 8'h01);
    chk(32'(nf), 32'h1);
    csr(32'h0000_1790);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd, 32'h0000_1000);
    end_of_test();
  end
endmodule
`default_nettype wire
